// File: pkg/opdec_pkg.sv
// Opcode constants and enumerations for the long-mode legality decoder
`default_nettype none
package opdec_pkg;
  typedef enum logic [1:0] {MODE_LEGACY, MODE_COMPAT, MODE_64BIT} cpu_mode_t;
  typedef enum logic [2:0] {
    CLASS_NORMAL, CLASS_PREFIX, CLASS_SIGN_WIDEN, CLASS_PRIV_ADJUST,
    CLASS_STEP_ONE, CLASS_MEDIA_STATE, CLASS_INVALID
  } op_class_t;
  localparam logic [7:0] OP_PREFIX_LO     = 8'h40;
  localparam logic [7:0] OP_PREFIX_HI     = 8'h4F;
  localparam logic [7:0] OP_SIGN_WIDEN    = 8'h63;
  localparam logic [7:0] OP_GROUP5        = 8'hFF;
  localparam logic [7:0] OP_ESCAPE        = 8'h0F;
  localparam logic [7:0] OP2_FAST_ENTRY   = 8'h34;
  localparam logic [7:0] OP2_FAST_RETURN  = 8'h35;
  localparam logic [7:0] OP2_MEDIA_GROUP  = 8'hAE;
  localparam logic [2:0] REG_MEDIA_STORE  = 3'h0;
  localparam logic [2:0] REG_MEDIA_LOAD   = 3'h1;
  localparam logic [2:0] REG_ADD_ONE      = 3'h0;
  localparam logic [2:0] REG_SUB_ONE      = 3'h1;
  localparam int         NUM_INVALID_64   = 23;
  localparam logic [7:0] INVALID_64_OPS [NUM_INVALID_64] = '{
    8'h37, 8'hD5, 8'hD4, 8'h3F, 8'h27, 8'h2F,
    8'h9A, 8'hEA, 8'h62, 8'hCE, 8'hC5, 8'hC4,
    8'h1F, 8'h07, 8'h17, 8'h0E, 8'h1E, 8'h06, 8'h16,
    8'h60, 8'h61, 8'h82, 8'hD6
  };
  localparam logic       FAST_MEDIA_SAVE_PRESENT = 1'b1;
  localparam logic [1:0] PRIV_LEVEL_ZERO = 2'h0;
endpackage
`default_nettype wire

// File: core/invalid_op_match.sv
// Matches a primary opcode against the 64-bit-mode illegal list
`default_nettype none
module invalid_op_match (
  input  wire logic [7:0] opcode_in,
  output logic            match_out
);
  import opdec_pkg::*;
  logic [NUM_INVALID_64-1:0] hit;
  genvar i;
  generate
    for (i = 0; i < NUM_INVALID_64; i++) begin : g_cmp
      assign hit[i] = (opcode_in == INVALID_64_OPS[i]);
    end
  endgenerate
  assign match_out = |hit;
endmodule
`default_nettype wire

// File: core/media_state_select.sv
// Chooses save image format and XMM coverage for media state store and load
`default_nettype none
module media_state_select (
  input  wire logic      opsize64_in,
  input  wire opdec_pkg::cpu_mode_t mode_in,
  input  wire logic [1:0] priv_level_in,
  input  wire logic      fast_media_save_enable_in,
  output logic           expanded_image_out,
  output logic           skip_xmm_out,
  output logic           save_env_out
);
  import opdec_pkg::*;
  // Expanded image carries 64-bit pointers and XMM8-15
  assign expanded_image_out = opsize64_in; // RL13
  // Enable bit only matters in 64-bit mode at level zero
  assign skip_xmm_out = fast_media_save_enable_in && (mode_in == MODE_64BIT)
                        && (priv_level_in == PRIV_LEVEL_ZERO); // RL14 RL16
  assign save_env_out = 1'b1; // RL15
endmodule
`default_nettype wire

// File: core/long_mode_opcode_legality_decode.sv
// Opcode legality and reinterpretation stage for a long-mode capable core
//
// Contract
// RL1 - 40-4F are extension prefixes in 64-bit mode
// RL2 - FF /0 and /1 still add/subtract one
// RL3 - 63 sign-widens in 64-bit, else privilege adjust
// RL4 - Sign-widen reads 32 bits, extends with prefix
// RL5 - Ascii/decimal adjust opcodes fault in 64-bit
// RL6 - Far absolute call/jump fault in 64-bit
// RL7 - Range check and overflow trap fault
// RL8 - Far pointer segment loads fault in 64-bit
// RL9 - Segment stack push/pop opcodes fault
// RL10 - Push-all and pop-all fault in 64-bit
// RL11 - Opcodes 82 and D6 fault in 64-bit
// RL12 - Fast system entry/return fault in long mode
// RL13 - Operand size picks legacy or expanded image
// RL14 - Fast save skips XMM in 64-bit level zero
// RL15 - x87 environment and control always transferred
// RL16 - Fast save ignored outside 64-bit or level>0
// RL17 - Feature query bit reports fast save support
// RL18 - Fault raised before any state changes
`default_nettype none
module long_mode_opcode_legality_decode
  import opdec_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 op_valid_in,
  input  wire logic [7:0]           opcode_in,
  input  wire logic                 escape_in,
  input  wire logic [7:0]           modrm_in,
  input  wire logic                 prefix_wide_in,
  input  wire opdec_pkg::cpu_mode_t mode_in,
  input  wire logic [1:0]           priv_level_in,
  input  wire logic                 opsize64_in,
  input  wire logic                 fast_media_save_enable_in,
  input  wire logic [31:0]          src_dword_in,
  output logic                      decode_valid_out,
  output opdec_pkg::op_class_t      op_class_out,
  output logic                      invalid_opcode_fault_out,
  output logic                      commit_out,
  output logic                      step_sub_out,
  output logic [63:0]               widen_result_out,
  output logic                      expanded_image_out,
  output logic                      skip_xmm_out,
  output logic                      save_env_out,
  output logic                      fast_save_feature_out
);
  import opdec_pkg::*;

  wire logic mode64     = (mode_in == MODE_64BIT);
  wire logic long_mode  = (mode_in == MODE_64BIT) || (mode_in == MODE_COMPAT);
  wire logic [2:0] reg_field = modrm_in[5:3];
  wire logic list_hit;
  wire logic sel_expanded;
  wire logic sel_skip;
  wire logic sel_env;

  invalid_op_match u_match (
    .opcode_in (opcode_in),
    .match_out (list_hit)
  );

  media_state_select u_media (
    .opsize64_in               (opsize64_in),
    .mode_in                   (mode_in),
    .priv_level_in             (priv_level_in),
    .fast_media_save_enable_in (fast_media_save_enable_in),
    .expanded_image_out        (sel_expanded),
    .skip_xmm_out              (sel_skip),
    .save_env_out              (sel_env)
  );

  wire logic is_prefix_byte = !escape_in && (opcode_in >= OP_PREFIX_LO) && (opcode_in <= OP_PREFIX_HI);
  wire logic is_sign_widen  = !escape_in && (opcode_in == OP_SIGN_WIDEN);
  wire logic is_step_one    = !escape_in && (opcode_in == OP_GROUP5)
                              && ((reg_field == REG_ADD_ONE) || (reg_field == REG_SUB_ONE));
  wire logic is_fast_sys    = escape_in && ((opcode_in == OP2_FAST_ENTRY) || (opcode_in == OP2_FAST_RETURN));
  wire logic is_media_state = escape_in && (opcode_in == OP2_MEDIA_GROUP)
                              && ((reg_field == REG_MEDIA_STORE) || (reg_field == REG_MEDIA_LOAD));
  wire logic illegal_64     = mode64 && !escape_in && list_hit; // RL5 RL6 RL7 RL8 RL9 RL10 RL11
  wire logic illegal_long   = long_mode && is_fast_sys; // RL12
  wire logic fault          = illegal_64 || illegal_long;

  op_class_t next_class;
  always_comb begin
    if (fault)
      next_class = CLASS_INVALID;
    else if (is_prefix_byte && mode64)
      next_class = CLASS_PREFIX; // RL1
    else if (is_sign_widen)
      next_class = mode64 ? CLASS_SIGN_WIDEN : CLASS_PRIV_ADJUST; // RL3
    else if (is_step_one)
      next_class = CLASS_STEP_ONE; // RL2
    else if (is_media_state)
      next_class = CLASS_MEDIA_STATE;
    else
      next_class = CLASS_NORMAL;
  end

  // Upper half is sign copies only with the wide prefix; else zero-extended dword
  wire logic [63:0] next_widen = prefix_wide_in ? {{32{src_dword_in[31]}}, src_dword_in}
                                                 : {32'h0000_0000, src_dword_in}; // RL4

  // Commit is withheld in the same cycle a fault is flagged, so nothing retires
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      decode_valid_out         <= 1'b0;
      op_class_out             <= CLASS_NORMAL;
      invalid_opcode_fault_out <= 1'b0;
      commit_out               <= 1'b0;
      step_sub_out             <= 1'b0;
      widen_result_out         <= 64'h0000_0000_0000_0000;
      expanded_image_out       <= 1'b0;
      skip_xmm_out             <= 1'b0;
      save_env_out             <= 1'b0;
      fast_save_feature_out    <= 1'b0;
    end else begin
      decode_valid_out         <= op_valid_in;
      op_class_out             <= op_valid_in ? next_class : CLASS_NORMAL;
      invalid_opcode_fault_out <= op_valid_in && fault;
      commit_out               <= op_valid_in && !fault; // RL18
      step_sub_out             <= op_valid_in && is_step_one && (reg_field == REG_SUB_ONE); // RL2
      widen_result_out         <= next_widen;
      expanded_image_out       <= op_valid_in && is_media_state && sel_expanded; // RL13
      skip_xmm_out             <= op_valid_in && is_media_state && sel_skip; // RL14 RL16
      save_env_out             <= op_valid_in && is_media_state && sel_env; // RL15
      fast_save_feature_out    <= FAST_MEDIA_SAVE_PRESENT; // RL17
    end
  end

  AST_PREFIX_64: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL1
    op_valid_in && mode64 && is_prefix_byte |=> op_class_out == CLASS_PREFIX)
    else $error("prefix byte not classed as prefix");
  AST_STEP_ONE: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL2
    op_valid_in && is_step_one |=> op_class_out == CLASS_STEP_ONE && !invalid_opcode_fault_out)
    else $error("group five step form not decoded");
  AST_OP63: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL3
    op_valid_in && is_sign_widen && !mode64 |=> op_class_out == CLASS_PRIV_ADJUST)
    else $error("63 outside 64-bit not privilege adjust");
  AST_WIDEN: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL4
    prefix_wide_in |=> widen_result_out[63:32] == {32{$past(src_dword_in[31])}})
    else $error("sign widening wrong");
  AST_FAULT_64: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL5
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h37 || opcode_in == 8'hD6)
    |=> invalid_opcode_fault_out && op_class_out == CLASS_INVALID)
    else $error("listed opcode did not fault");
  AST_NO_FAULT_LEGACY: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL6
    op_valid_in && mode_in == MODE_LEGACY |=> !invalid_opcode_fault_out)
    else $error("fault raised in legacy mode");
  AST_FAST_SYS: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL12
    op_valid_in && mode_in == MODE_COMPAT && is_fast_sys |=> invalid_opcode_fault_out)
    else $error("fast system op not refused in compat mode");
  AST_NO_COMMIT: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL18
    !(commit_out && invalid_opcode_fault_out))
    else $error("faulting op committed");
  AST_SKIP_GATE: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL16
    skip_xmm_out |-> $past(mode64) && $past(priv_level_in) == PRIV_LEVEL_ZERO)
    else $error("xmm skipped outside 64-bit level zero");
  AST_ENV: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL15
    op_valid_in && is_media_state |=> save_env_out)
    else $error("environment not transferred");
  AST_IMAGE: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RL13
    op_valid_in && is_media_state |=> expanded_image_out == $past(opsize64_in))
    else $error("image format mismatch");

  // Prefix bytes and the group five step forms
  AST_PREFIX_QUIET: assert property ( // RL1
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && is_prefix_byte
    |=> !invalid_opcode_fault_out && !step_sub_out && commit_out)
    else $error("prefix byte decoded as an operation");
  AST_PREFIX_LEGACY: assert property ( // RL1
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && !mode64 && is_prefix_byte
    |=> op_class_out == CLASS_NORMAL && !invalid_opcode_fault_out)
    else $error("byte 40 to 4F classed as prefix outside 64-bit");
  AST_STEP_SUB: assert property ( // RL2
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && is_step_one
    |=> step_sub_out == $past(modrm_in[3]))
    else $error("step direction wrong");
  AST_STEP_COMMIT: assert property ( // RL2
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && is_step_one
    |=> commit_out && !invalid_opcode_fault_out)
    else $error("step form not executed in 64-bit");

  // Sign widening move
  AST_OP63_64: assert property ( // RL3
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && is_sign_widen && mode64
    |=> op_class_out == CLASS_SIGN_WIDEN && commit_out)
    else $error("63 in 64-bit not sign widen");
  AST_ZERO_WIDEN: assert property ( // RL4
    @(posedge core_clk_in) disable iff (!resetn_in)
    !prefix_wide_in
    |=> widen_result_out[63:32] == 32'h0000_0000)
    else $error("upper half not zero without prefix");
  AST_WIDEN_LOW: assert property ( // RL4
    @(posedge core_clk_in) disable iff (!resetn_in)
    1'b1
    |=> widen_result_out[31:0] == $past(src_dword_in))
    else $error("source dword not carried");

  // Opcodes refused in 64-bit mode, one property per group
  AST_ASCII_ADJ: assert property ( // RL5
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h37 || opcode_in == 8'hD5 || opcode_in == 8'hD4
    || opcode_in == 8'h3F || opcode_in == 8'h27 || opcode_in == 8'h2F)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("adjust opcode did not fault");
  AST_FAR_ABS: assert property ( // RL6
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h9A || opcode_in == 8'hEA)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("far absolute branch did not fault");
  AST_RANGE_TRAP: assert property ( // RL7
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h62 || opcode_in == 8'hCE)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("range check or overflow trap did not fault");
  AST_FAR_PTR: assert property ( // RL8
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'hC5 || opcode_in == 8'hC4)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("far pointer load did not fault");
  AST_SEG_STACK: assert property ( // RL9
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h1F || opcode_in == 8'h07 || opcode_in == 8'h17
    || opcode_in == 8'h0E || opcode_in == 8'h1E || opcode_in == 8'h06 || opcode_in == 8'h16)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("segment stack opcode did not fault");
  AST_STACK_ALL: assert property ( // RL10
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h60 || opcode_in == 8'h61)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("save or restore all did not fault");
  AST_REDUNDANT: assert property ( // RL11
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && !escape_in && (opcode_in == 8'h82 || opcode_in == 8'hD6)
    |=> invalid_opcode_fault_out && !commit_out && op_class_out == CLASS_INVALID)
    else $error("82 or D6 did not fault");

  // Fast system entry and return across modes
  AST_FAST_SYS_64: assert property ( // RL12
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode64 && is_fast_sys
    |=> invalid_opcode_fault_out && !commit_out)
    else $error("fast system op not refused in 64-bit");
  AST_FAST_SYS_LEGACY: assert property ( // RL12
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && mode_in == MODE_LEGACY && is_fast_sys
    |=> !invalid_opcode_fault_out && commit_out)
    else $error("fast system op refused in legacy mode");

  // Media state image and register coverage
  AST_IMAGE_IDLE: assert property ( // RL13
    @(posedge core_clk_in) disable iff (!resetn_in)
    !op_valid_in
    |=> !expanded_image_out && !skip_xmm_out && !save_env_out)
    else $error("media selects raised with no op");
  AST_SKIP_SET: assert property ( // RL14
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && is_media_state && fast_media_save_enable_in && mode64 && priv_level_in == PRIV_LEVEL_ZERO
    |=> skip_xmm_out && save_env_out)
    else $error("fast save did not skip xmm");
  AST_SKIP_PRIV: assert property ( // RL16
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && is_media_state && priv_level_in != PRIV_LEVEL_ZERO
    |=> !skip_xmm_out && save_env_out)
    else $error("xmm skipped above level zero");
  AST_SKIP_MODE: assert property ( // RL16
    @(posedge core_clk_in) disable iff (!resetn_in)
    op_valid_in && is_media_state && !mode64
    |=> !skip_xmm_out && save_env_out)
    else $error("xmm skipped outside 64-bit");
  AST_FEATURE: assert property ( // RL17
    @(posedge core_clk_in) disable iff (!resetn_in)
    1'b1
    |=> fast_save_feature_out)
    else $error("fast save feature bit not reported");

  // Fault and commit never overlap, so a refused op raises no commit, step or media result (widen_result_out still updates)
  AST_VALID_ECHO: assert property ( // RL18
    @(posedge core_clk_in) disable iff (!resetn_in)
    1'b1
    |=> decode_valid_out == $past(op_valid_in))
    else $error("decode valid not one cycle after request");
  AST_COMMIT_PAIR: assert property ( // RL18
    @(posedge core_clk_in) disable iff (!resetn_in)
    decode_valid_out
    |-> commit_out != invalid_opcode_fault_out)
    else $error("valid op neither committed nor faulted");
  AST_IDLE_QUIET: assert property ( // RL18
    @(posedge core_clk_in) disable iff (!resetn_in)
    !decode_valid_out
    |-> !commit_out && !invalid_opcode_fault_out && op_class_out == CLASS_NORMAL)
    else $error("result raised with no valid op");
  AST_INVALID_CLASS: assert property ( // RL18
    @(posedge core_clk_in) disable iff (!resetn_in)
    invalid_opcode_fault_out
    |-> op_class_out == CLASS_INVALID)
    else $error("fault without invalid class");
  AST_FAULT_SILENT: assert property ( // RL18
    @(posedge core_clk_in) disable iff (!resetn_in)
    invalid_opcode_fault_out
    |-> !step_sub_out && !expanded_image_out && !skip_xmm_out && !save_env_out)
    else $error("faulting op drove side results");
endmodule
`default_nettype wire

// File: sim/pipeline_sink.sv
// Execution pipeline model that flags any decoded op that both traps and retires
`default_nettype none
module pipeline_sink (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic decode_valid_in,
  input  wire logic fault_in,
  input  wire logic commit_in,
  output logic      clash_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sticky, so one trapped op that also retires is never lost
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) clash_out <= 1'b0;
    else if (decode_valid_in && fault_in && commit_in) clash_out <= 1'b1;
  end
endmodule
`default_nettype wire

// File: sim/long_mode_opcode_legality_decode_tb.sv
// Self-checking bench for the long-mode opcode legality decoder
`default_nettype none
module long_mode_opcode_legality_decode_tb;
  import opdec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, vld, esc, wide, os, fx, dv, flt, cmt, sub, exp_img, skip, env, feat, clash;
  logic [7:0] opc, mrm;
  logic [1:0] pl;
  logic [31:0] src;
  logic [63:0] res;
  cpu_mode_t md;
  op_class_t cls;
  int errors, cmp_count, cycles;
  logic [7:0] bad_ops [23] = '{8'h37, 8'hD5, 8'hD4, 8'h3F, 8'h27, 8'h2F, 8'h9A, 8'hEA, 8'h62, 8'hCE,
    8'hC5, 8'hC4, 8'h1F, 8'h07, 8'h17, 8'h0E, 8'h1E, 8'h06, 8'h16, 8'h60, 8'h61, 8'h82, 8'hD6};
  long_mode_opcode_legality_decode uut (.core_clk_in(clk), .resetn_in(rstn), .op_valid_in(vld),
    .opcode_in(opc), .escape_in(esc), .modrm_in(mrm), .prefix_wide_in(wide), .mode_in(md),
    .priv_level_in(pl), .opsize64_in(os), .fast_media_save_enable_in(fx), .src_dword_in(src),
    .decode_valid_out(dv), .op_class_out(cls), .invalid_opcode_fault_out(flt), .commit_out(cmt),
    .step_sub_out(sub), .widen_result_out(res), .expanded_image_out(exp_img), .skip_xmm_out(skip),
    .save_env_out(env), .fast_save_feature_out(feat));
  pipeline_sink sink (.core_clk_in(clk), .resetn_in(rstn), .decode_valid_in(dv), .fault_in(flt),
    .commit_in(cmt), .clash_out(clash));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_cls(input string what, input op_class_t e, input op_class_t g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic chk_word(input string what, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // One op per call; results are looked at 1 ns after the answering edge
  task automatic issue(input logic [7:0] o, input logic e, input logic [7:0] m, input cpu_mode_t d,
                       input logic [1:0] p, input logic s, input logic f, input logic w);
    @(posedge clk);
    {vld, opc, esc, mrm, pl, os, fx, wide} <= {1'b1, o, e, m, p, s, f, w};
    md <= d;
    @(posedge clk);
    #1;
    chk_bit("decode_valid", 1'b1, dv);
  endtask
  initial begin
    {rstn, vld, esc, wide, os, fx, opc, mrm, pl} = '0;
    md = MODE_LEGACY;
    src = 32'h8000_0001;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk_bit("reset_fault", 1'b0, flt);
    foreach (bad_ops[i]) begin
      issue(bad_ops[i], 1'b0, 8'h00, MODE_64BIT, 2'h0, 1'b0, 1'b0, 1'b0);
      chk_bit("fault64", 1'b1, flt);
      chk_cls("class64", CLASS_INVALID, cls);
      chk_bit("commit64", 1'b0, cmt);
      issue(bad_ops[i], 1'b0, 8'h00, MODE_LEGACY, 2'h0, 1'b0, 1'b0, 1'b0);
      chk_bit("fault_legacy", 1'b0, flt);
      chk_bit("commit_legacy", 1'b1, cmt);
    end
    for (int b = 8'h40; b <= 8'h4F; b++) begin
      issue(b[7:0], 1'b0, 8'h00, MODE_64BIT, 2'h0, 1'b0, 1'b0, 1'b0);
      chk_cls("prefix", CLASS_PREFIX, cls);
      issue(b[7:0], 1'b0, 8'h00, MODE_LEGACY, 2'h0, 1'b0, 1'b0, 1'b0);
      chk_cls("prefix_legacy", CLASS_NORMAL, cls);
    end
    for (int r = 0; r < 2; r++) begin
      issue(8'hFF, 1'b0, {4'hC, r[0], 3'h0}, MODE_64BIT, 2'h0, 1'b0, 1'b0, 1'b0);
      chk_cls("step_class", CLASS_STEP_ONE, cls);
      chk_bit("step_sub", r[0], sub);
      chk_bit("step_commit", 1'b1, cmt);
    end
    issue(8'h63, 1'b0, 8'hC0, MODE_64BIT, 2'h0, 1'b1, 1'b0, 1'b1);
    chk_cls("widen_class", CLASS_SIGN_WIDEN, cls);
    chk_word("widen_sext", 64'hFFFF_FFFF_8000_0001, res);
    issue(8'h63, 1'b0, 8'hC0, MODE_64BIT, 2'h0, 1'b0, 1'b0, 1'b0);
    chk_word("widen_zext", 64'h0000_0000_8000_0001, res);
    issue(8'h63, 1'b0, 8'hC0, MODE_COMPAT, 2'h0, 1'b0, 1'b0, 1'b0);
    chk_cls("priv_adjust", CLASS_PRIV_ADJUST, cls);
    for (int k = 0; k < 6; k++) begin
      issue(8'h34 + k[0], 1'b1, 8'h00, cpu_mode_t'(k / 2), 2'h0, 1'b0, 1'b0, 1'b0);
      chk_bit("fast_sys", (k / 2) != 0, flt);
    end
    for (int k = 0; k < 48; k++) begin
      issue(8'hAE, 1'b1, {4'h0, k[0], 3'h0}, cpu_mode_t'(k / 16), {2{k[1]}}, k[2], k[3], 1'b0);
      chk_bit("expanded", k[2], exp_img);
      chk_bit("skip_xmm", k[3] && (k / 16) == 2 && !k[1], skip);
      chk_bit("save_env", 1'b1, env);
    end
    chk_bit("feature", 1'b1, feat);
    chk_bit("clash", 1'b0, clash);
    end_of_test();
  end
endmodule
`default_nettype wire
